// File: include/mie_pkg.sv
// Constants, opcodes and state codes of the execute unit.
package mie_pkg;

  // Data path widths and fixed byte values.
  localparam int MIE_DATA_W = 8;
  localparam int MIE_ROM_W = 16;
  localparam int MIE_BIT_W = 3;
  localparam logic [7:0] MIE_BYTE_ZERO = 8'h00;
  localparam logic [7:0] MIE_BYTE_ONES = 8'hFF;
  localparam logic [7:0] MIE_BIT0_MASK = 8'h01;
  localparam logic [7:0] MIE_ONE_BYTE = 8'h01;

  // Default widths and reset values of the core state.
  localparam int MIE_PC_W_DEF = 14;
  localparam int MIE_STACK_DEPTH_DEF = 8;
  localparam logic [7:0] MIE_PCL_ADDR_DEF = 8'h02;
  localparam logic [7:0] MIE_WREG_RESET = 8'h00;
  localparam logic [15:0] MIE_PC_RESET = 16'h0000;

  // Decoded instruction codes from the fetch stage.
  typedef enum logic [5:0] {
    MIE_OP_NOP        = 6'h00,
    MIE_OP_ADC_W      = 6'h01,
    MIE_OP_ADC_M      = 6'h02,
    MIE_OP_ADD_W_MEM  = 6'h03,
    MIE_OP_ADD_W_IMM  = 6'h04,
    MIE_OP_ADD_M      = 6'h05,
    MIE_OP_AND_W_MEM  = 6'h06,
    MIE_OP_AND_W_IMM  = 6'h07,
    MIE_OP_AND_M      = 6'h08,
    MIE_OP_JUMP       = 6'h09,
    MIE_OP_SKZ        = 6'h0A,
    MIE_OP_SKZ_W      = 6'h0B,
    MIE_OP_SKZ_BIT    = 6'h0C,
    MIE_OP_SKNZ_BIT   = 6'h0D,
    MIE_OP_SKINC      = 6'h0E,
    MIE_OP_SKDEC      = 6'h0F,
    MIE_OP_SKINC_W    = 6'h10,
    MIE_OP_SKDEC_W    = 6'h11,
    MIE_OP_CALL       = 6'h12,
    MIE_OP_RETURN     = 6'h13,
    MIE_OP_RETURN_IMM = 6'h14,
    MIE_OP_RETURN_INT = 6'h15,
    MIE_OP_TBL_CUR    = 6'h16,
    MIE_OP_TBL_LAST   = 6'h17,
    MIE_OP_CLR_M      = 6'h18,
    MIE_OP_SET_M      = 6'h19,
    MIE_OP_CLR_BIT    = 6'h1A,
    MIE_OP_WDOG_CLR   = 6'h1B,
    MIE_OP_WDOG_PRE1  = 6'h1C,
    MIE_OP_WDOG_PRE2  = 6'h1D,
    MIE_OP_SWAP_M     = 6'h1E,
    MIE_OP_SWAP_W     = 6'h1F,
    MIE_OP_HALT       = 6'h20
  } mie_op_t;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    MIE_ST_EXEC  = 4'h1,
    MIE_ST_DUMMY = 4'h2,
    MIE_ST_TABLE = 4'h4,
    MIE_ST_HALT  = 4'h8
  } mie_state_t;

  // Last watchdog pre-clear seen, for the two-step pair.
  typedef enum logic [1:0] {
    MIE_PRE_NONE   = 2'h0,
    MIE_PRE_FIRST  = 2'h1,
    MIE_PRE_SECOND = 2'h2
  } mie_pre_t;

endpackage

// File: core/mie_core.sv
// Instruction execute unit of an 8-bit microcontroller core.
//
// Contract
// - Skip taking effect costs two cycles, no skip costs one.
// - Any write landing on the program counter low byte costs two cycles.
// - Pre-clear pair clears timeout and power-down flags only back to back.
// - Add with carry to working register updates overflow, zero, aux, carry.
// - Add with carry to memory writes byte, updates the four flags.
// - Plain add from memory or immediate ignores carry in, sets four flags.
// - AND to working register or memory touches only the zero flag.
// - Call pushes program counter plus one, loads target, two cycles.
// - Jump loads target, two cycles, no flags.
// - All three returns take two cycles; all but return from interrupt touch no flags.
// - Table read from current or last page fills high reg and memory.
// - Skip on zero byte, bit test, or incremented/decremented byte zero.
// - Clear byte writes zero with no flag change.
// - Bit clear forces only the chosen bit low.
// - Single watchdog clear resets counter, clears both flags, one cycle.
// - Nibble swap to memory or working register, one cycle, no flags.
// - Set byte writes all ones; no-operation does nothing; one cycle.
// - Halt enters power-down in one cycle, touching only those two flags.
// - Halt stops the clock, keeps state, clears watchdog, sets power-down.
// - Return from interrupt restores the counter and sets interrupt enable.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module mie_core #(
  parameter int PC_W = mie_pkg::MIE_PC_W_DEF,
  parameter int STACK_DEPTH = mie_pkg::MIE_STACK_DEPTH_DEF,
  parameter logic [7:0] PCL_ADDR = mie_pkg::MIE_PCL_ADDR_DEF
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Decoded instruction from the fetch stage.
  input wire logic instr_valid_in,
  input wire mie_pkg::mie_op_t instr_op_in,
  input wire logic [7:0] instr_mem_addr_in,
  input wire logic [7:0] instr_imm_in,
  input wire logic [2:0] instr_bit_in,
  input wire logic [PC_W-1:0] instr_target_in,
  input wire logic [7:0] mem_operand_in,
  output logic instr_ready_out,
  output logic [PC_W-1:0] pc_out,
  // Data memory write port.
  output logic mem_we_out,
  output logic [7:0] mem_waddr_out,
  output logic [7:0] mem_wdata_out,
  // Program memory table port.
  input wire logic [7:0] table_pointer_in,
  input wire logic [15:0] rom_rdata_in,
  output logic rom_re_out,
  output logic [PC_W-1:0] rom_addr_out,
  // Working register and status.
  output logic [7:0] working_register_out,
  output logic [7:0] table_high_byte_reg_out,
  output logic carry_flag_out,
  output logic auxiliary_carry_flag_out,
  output logic zero_flag_out,
  output logic signed_overflow_flag_out,
  output logic watchdog_timeout_flag_out,
  output logic power_down_flag_out,
  output logic master_interrupt_enable_out,
  // Watchdog and power-down control.
  input wire logic wdog_timeout_in,
  input wire logic wake_in,
  output logic watchdog_clear_out,
  output logic halted_out
);
  import mie_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  // Refuse unservable shapes.
  if (PC_W <= MIE_DATA_W || PC_W > MIE_ROM_W) begin : g_bad_pc
    $error("mie_core: PC_W must be 9 to 16");
  end
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_stack
    $error("mie_core: STACK_DEPTH must be a power of two, at least 2");
  end

  // Sum of two bytes and a carry: {overflow, aux carry, carry, sum}.
  function automatic logic [10:0] mie_add(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    logic ovf;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    ovf = (a[7] == b[7]) && (full[7] != a[7]);
    return {ovf, low[4], full[8], full[7:0]};
  endfunction

  // Registers.
  mie_state_t state_r;
  mie_pre_t pre_last_r;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [7:0] wreg_r;
  logic c_r, ac_r, z_r, ov_r, to_r, pd_r, ie_r;
  logic [7:0] table_high_byte_reg_r;
  logic mem_we_r;
  logic [7:0] mem_waddr_r, mem_wdata_r, tbl_dest_r;
  logic rom_re_r;
  logic [PC_W-1:0] rom_addr_r;
  logic wdog_clr_r;
  logic wake_q1_r, wake_q2_r, wake_q3_r;

  // Decode results.
  logic accept;
  logic [7:0] opnd, res;
  logic [10:0] sum;
  logic wr_mem, wr_w, upd_arith, upd_z, skip, jump, push, pop;
  logic two_cyc, tbl, tbl_last, wd_clr, pre1, pre2, halt, set_ie;
  logic pcl_hit, pre_pair, wake_ok;
  logic [PC_W-1:0] pc_inc, pc_nxt;

  assign accept = instr_valid_in && (state_r == MIE_ST_EXEC);
  assign instr_ready_out = (state_r == MIE_ST_EXEC);
  assign pc_inc = pc_r + PC_W'(1);

  // Forward last cycle's write; memory shows it one cycle late.
  assign opnd = (mem_we_r && mem_waddr_r == instr_mem_addr_in) ?
                mem_wdata_r : mem_operand_in;

  // Wake counts once stages two and three agree high.
  assign wake_ok = wake_q2_r && wake_q3_r;

  // Decode and arithmetic/logic results.
  always_comb begin
    res = opnd;
    sum = mie_add(wreg_r, opnd, 1'b0);
    wr_mem = 1'b0;
    wr_w = 1'b0;
    upd_arith = 1'b0;
    upd_z = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    two_cyc = 1'b0;
    tbl = 1'b0;
    tbl_last = 1'b0;
    wd_clr = 1'b0;
    pre1 = 1'b0;
    pre2 = 1'b0;
    halt = 1'b0;
    set_ie = 1'b0;
    case (instr_op_in)
      MIE_OP_ADC_W, MIE_OP_ADC_M: begin
        sum = mie_add(wreg_r, opnd, c_r);
        res = sum[7:0];
        upd_arith = 1'b1;
        wr_w = (instr_op_in == MIE_OP_ADC_W);
        wr_mem = (instr_op_in == MIE_OP_ADC_M);
      end
      MIE_OP_ADD_W_MEM, MIE_OP_ADD_M: begin
        res = sum[7:0];
        upd_arith = 1'b1;
        wr_w = (instr_op_in == MIE_OP_ADD_W_MEM);
        wr_mem = (instr_op_in == MIE_OP_ADD_M);
      end
      MIE_OP_ADD_W_IMM: begin
        sum = mie_add(wreg_r, instr_imm_in, 1'b0);
        res = sum[7:0];
        upd_arith = 1'b1;
        wr_w = 1'b1;
      end
      MIE_OP_AND_W_MEM, MIE_OP_AND_M: begin
        res = wreg_r & opnd;
        upd_z = 1'b1;
        wr_w = (instr_op_in == MIE_OP_AND_W_MEM);
        wr_mem = (instr_op_in == MIE_OP_AND_M);
      end
      MIE_OP_AND_W_IMM: begin
        res = wreg_r & instr_imm_in;
        upd_z = 1'b1;
        wr_w = 1'b1;
      end
      MIE_OP_JUMP: begin
        jump = 1'b1;
        two_cyc = 1'b1;
      end
      MIE_OP_CALL: begin
        jump = 1'b1;
        push = 1'b1;
        two_cyc = 1'b1;
      end
      MIE_OP_RETURN, MIE_OP_RETURN_INT: begin
        pop = 1'b1;
        two_cyc = 1'b1;
        set_ie = (instr_op_in == MIE_OP_RETURN_INT);
      end
      MIE_OP_RETURN_IMM: begin
        pop = 1'b1;
        two_cyc = 1'b1;
        res = instr_imm_in;
        wr_w = 1'b1;
      end
      MIE_OP_SKZ, MIE_OP_SKZ_W: begin
        skip = (opnd == MIE_BYTE_ZERO);
        wr_w = (instr_op_in == MIE_OP_SKZ_W);
      end
      MIE_OP_SKZ_BIT: skip = ~opnd[instr_bit_in];
      MIE_OP_SKNZ_BIT: skip = opnd[instr_bit_in];
      MIE_OP_SKINC, MIE_OP_SKINC_W: begin
        res = opnd + MIE_ONE_BYTE;
        skip = (res == MIE_BYTE_ZERO);
        wr_w = (instr_op_in == MIE_OP_SKINC_W);
        wr_mem = (instr_op_in == MIE_OP_SKINC);
      end
      MIE_OP_SKDEC, MIE_OP_SKDEC_W: begin
        res = opnd - MIE_ONE_BYTE;
        skip = (res == MIE_BYTE_ZERO);
        wr_w = (instr_op_in == MIE_OP_SKDEC_W);
        wr_mem = (instr_op_in == MIE_OP_SKDEC);
      end
      MIE_OP_TBL_CUR, MIE_OP_TBL_LAST: begin
        tbl = 1'b1;
        tbl_last = (instr_op_in == MIE_OP_TBL_LAST);
      end
      MIE_OP_CLR_M: begin
        res = MIE_BYTE_ZERO;
        wr_mem = 1'b1;
      end
      MIE_OP_SET_M: begin
        res = MIE_BYTE_ONES;
        wr_mem = 1'b1;
      end
      MIE_OP_CLR_BIT: begin
        res = opnd & ~(MIE_BIT0_MASK << instr_bit_in);
        wr_mem = 1'b1;
      end
      MIE_OP_SWAP_M, MIE_OP_SWAP_W: begin
        res = {opnd[3:0], opnd[7:4]};
        wr_mem = (instr_op_in == MIE_OP_SWAP_M);
        wr_w = (instr_op_in == MIE_OP_SWAP_W);
      end
      MIE_OP_WDOG_CLR: wd_clr = 1'b1;
      MIE_OP_WDOG_PRE1: pre1 = 1'b1;
      MIE_OP_WDOG_PRE2: pre2 = 1'b1;
      MIE_OP_HALT: halt = 1'b1;
      MIE_OP_NOP: res = opnd;
      default: res = opnd;
    endcase
  end

  // A write to the low byte of the counter needs a refetch slot.
  assign pcl_hit = wr_mem && (instr_mem_addr_in == PCL_ADDR);

  // A pair needs the other half just before.
  assign pre_pair = (pre1 && pre_last_r == MIE_PRE_SECOND) ||
                    (pre2 && pre_last_r == MIE_PRE_FIRST);

  // Next program counter.
  always_comb begin
    if (jump) begin
      pc_nxt = instr_target_in;
    end else if (pop) begin
      pc_nxt = stack_r[sp_r - SP_W'(1)];
    end else if (pcl_hit) begin
      pc_nxt = {pc_r[PC_W-1:MIE_DATA_W], res};
    end else if (skip) begin
      pc_nxt = pc_r + PC_W'(2);
    end else begin
      pc_nxt = pc_inc;
    end
  end

  // Sequencer: dummy, table and power-down slots.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= MIE_ST_EXEC;
    end else begin
      case (state_r)
        MIE_ST_EXEC: begin
          if (accept && halt) begin
            state_r <= MIE_ST_HALT;
          end else if (accept && tbl) begin
            state_r <= MIE_ST_TABLE;
          end else if (accept && (two_cyc || skip || pcl_hit)) begin
            state_r <= MIE_ST_DUMMY;
          end
        end
        MIE_ST_DUMMY: state_r <= MIE_ST_EXEC;
        MIE_ST_TABLE: state_r <= MIE_ST_EXEC;
        MIE_ST_HALT: begin
          if (wake_ok) begin
            state_r <= MIE_ST_EXEC;
          end
        end
        default: state_r <= MIE_ST_EXEC;
      endcase
    end
  end

  // Program counter; a table word aimed at the low byte also reloads it.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_r <= MIE_PC_RESET[PC_W-1:0];
    end else if (accept) begin
      pc_r <= pc_nxt;
    end else if (state_r == MIE_ST_TABLE && tbl_dest_r == PCL_ADDR) begin
      pc_r <= {pc_r[PC_W-1:MIE_DATA_W], rom_rdata_in[7:0]};
    end
  end

  // Return stack; overflow and underflow wrap around silently.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sp_r <= '0;
    end else if (accept && push) begin
      stack_r[sp_r] <= pc_inc;
      sp_r <= sp_r + SP_W'(1);
    end else if (accept && pop) begin
      sp_r <= sp_r - SP_W'(1);
    end
  end

  // Working register.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wreg_r <= MIE_WREG_RESET;
    end else if (accept && wr_w) begin
      wreg_r <= res;
    end
  end

  // Arithmetic flags.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      c_r <= 1'b0;
      ac_r <= 1'b0;
      z_r <= 1'b0;
      ov_r <= 1'b0;
    end else if (accept && upd_arith) begin
      ov_r <= sum[10];
      ac_r <= sum[9];
      c_r <= sum[8];
      z_r <= (res == MIE_BYTE_ZERO);
    end else if (accept && upd_z) begin
      z_r <= (res == MIE_BYTE_ZERO);
    end
  end

  // Timeout and power-down flags; a same-cycle timeout beats a clear.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      to_r <= 1'b0;
      pd_r <= 1'b0;
    end else begin
      if (accept && (wd_clr || pre_pair)) begin
        to_r <= 1'b0;
        pd_r <= 1'b0;
      end else if (accept && halt) begin
        to_r <= 1'b0;
        pd_r <= 1'b1;
      end
      if (wdog_timeout_in) begin
        to_r <= 1'b1;
      end
    end
  end

  // Pre-clear tracker; any other instruction breaks the pair.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre_last_r <= MIE_PRE_NONE;
    end else if (accept) begin
      if (pre_pair) begin
        pre_last_r <= MIE_PRE_NONE;
      end else if (pre1) begin
        pre_last_r <= MIE_PRE_FIRST;
      end else if (pre2) begin
        pre_last_r <= MIE_PRE_SECOND;
      end else begin
        pre_last_r <= MIE_PRE_NONE;
      end
    end
  end

  // One-cycle clear of the watchdog counter and prescaler.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wdog_clr_r <= 1'b0;
    end else begin
      wdog_clr_r <= accept && (wd_clr || pre_pair || halt);
    end
  end

  // Master interrupt enable, set on return from interrupt.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ie_r <= 1'b0;
    end else if (accept && set_ie) begin
      ie_r <= 1'b1;
    end
  end

  // Table fetch address; the last page is all ones above the pointer.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rom_re_r <= 1'b0;
      rom_addr_r <= '0;
      tbl_dest_r <= MIE_BYTE_ZERO;
    end else begin
      rom_re_r <= accept && tbl;
      if (accept && tbl) begin
        tbl_dest_r <= instr_mem_addr_in;
        rom_addr_r <= tbl_last ?
          {{(PC_W-MIE_DATA_W){1'b1}}, table_pointer_in} :
          {pc_r[PC_W-1:MIE_DATA_W], table_pointer_in};
      end
    end
  end

  // Table high byte register.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      table_high_byte_reg_r <= MIE_BYTE_ZERO;
    end else if (state_r == MIE_ST_TABLE) begin
      table_high_byte_reg_r <= rom_rdata_in[15:8];
    end
  end

  // Registered data memory write port.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_we_r <= 1'b0;
      mem_waddr_r <= MIE_BYTE_ZERO;
      mem_wdata_r <= MIE_BYTE_ZERO;
    end else if (state_r == MIE_ST_TABLE) begin
      mem_we_r <= 1'b1;
      mem_waddr_r <= tbl_dest_r;
      mem_wdata_r <= rom_rdata_in[7:0];
    end else begin
      mem_we_r <= accept && wr_mem;
      mem_waddr_r <= instr_mem_addr_in;
      mem_wdata_r <= res;
    end
  end

  // Wake pin synchroniser; only the second stage reads the first.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wake_q1_r <= 1'b0;
      wake_q2_r <= 1'b0;
      wake_q3_r <= 1'b0;
    end else begin
      wake_q1_r <= wake_in;
      wake_q2_r <= wake_q1_r;
      wake_q3_r <= wake_q2_r;
    end
  end

  // Outputs straight from registers.
  assign pc_out = pc_r;
  assign mem_we_out = mem_we_r;
  assign mem_waddr_out = mem_waddr_r;
  assign mem_wdata_out = mem_wdata_r;
  assign rom_re_out = rom_re_r;
  assign rom_addr_out = rom_addr_r;
  assign working_register_out = wreg_r;
  assign table_high_byte_reg_out = table_high_byte_reg_r;
  assign carry_flag_out = c_r;
  assign auxiliary_carry_flag_out = ac_r;
  assign zero_flag_out = z_r;
  assign signed_overflow_flag_out = ov_r;
  assign watchdog_timeout_flag_out = to_r;
  assign power_down_flag_out = pd_r;
  assign master_interrupt_enable_out = ie_r;
  assign watchdog_clear_out = wdog_clr_r;
  // Halt gates the system clock outside this block.
  assign halted_out = (state_r == MIE_ST_HALT);

endmodule

`default_nettype wire

// File: tb/mie_core_monitor.sv
// Port-level checks of the execute unit.
`timescale 1ns/1ps
`default_nettype none
module mie_core_monitor #(
  parameter int PC_W = mie_pkg::MIE_PC_W_DEF
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // Instruction port.
  input wire logic instr_valid_in,
  input wire mie_pkg::mie_op_t instr_op_in,
  input wire logic [7:0] instr_mem_addr_in,
  input wire logic [PC_W-1:0] instr_target_in,
  input wire logic [7:0] mem_operand_in,
  input wire logic wdog_timeout_in,
  input wire logic instr_ready_out,
  input wire logic [PC_W-1:0] pc_out,
  // Results and status.
  input wire logic mem_we_out,
  input wire logic [7:0] mem_waddr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic carry_flag_out,
  input wire logic auxiliary_carry_flag_out,
  input wire logic signed_overflow_flag_out,
  input wire logic watchdog_timeout_flag_out,
  input wire logic power_down_flag_out,
  input wire logic watchdog_clear_out,
  input wire logic halted_out
);
  import mie_pkg::*;
  logic take;
  mie_op_t last_r;
  // Taken when offered and ready.
  assign take = instr_valid_in && instr_ready_out;
  // Last taken opcode; idle cycles keep a pair.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      last_r <= MIE_OP_NOP;
    end else if (take) begin
      last_r <= instr_op_in;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_branch_target: assert property (
    take && instr_op_in inside {MIE_OP_JUMP, MIE_OP_CALL} |=>
    pc_out == $past(instr_target_in) && !instr_ready_out ##1 instr_ready_out)
    else $error("Branch wrong.");
  a_return_two_cycles: assert property (
    take && instr_op_in inside {MIE_OP_RETURN, MIE_OP_RETURN_IMM,
    MIE_OP_RETURN_INT} |=> !instr_ready_out ##1 instr_ready_out)
    else $error("Return wrong.");
  a_clear_byte_zero: assert property (
    take && instr_op_in == MIE_OP_CLR_M |=> mem_we_out &&
    mem_wdata_out == 8'h00 && mem_waddr_out == $past(instr_mem_addr_in))
    else $error("Clear wrong.");
  a_set_byte_ones: assert property (
    take && instr_op_in == MIE_OP_SET_M |=> mem_we_out &&
    mem_wdata_out == 8'hff) else $error("Byte set wrong.");
  a_wdog_clr_flags: assert property (
    take && instr_op_in == MIE_OP_WDOG_CLR && !wdog_timeout_in |=>
    watchdog_clear_out && !watchdog_timeout_flag_out && !power_down_flag_out)
    else $error("Watchdog clear wrong.");
  a_halt_power_down: assert property (
    take && instr_op_in == MIE_OP_HALT && !wdog_timeout_in |=> halted_out
    && power_down_flag_out && !watchdog_timeout_flag_out && watchdog_clear_out)
    else $error("Halt wrong.");
  a_and_flags_kept: assert property (
    take && instr_op_in inside {MIE_OP_AND_W_MEM, MIE_OP_AND_W_IMM,
    MIE_OP_AND_M} |=> $stable(carry_flag_out) && $stable(
    auxiliary_carry_flag_out) && $stable(signed_overflow_flag_out))
    else $error("AND flags wrong.");
  a_swap_nibbles: assert property (
    take && instr_op_in == MIE_OP_SWAP_M |=> mem_we_out && mem_wdata_out ==
    {$past(mem_operand_in[3:0]), $past(mem_operand_in[7:4])})
    else $error("Swap wrong.");
  a_lone_preclear: assert property (
    take && !wdog_timeout_in && (instr_op_in == MIE_OP_WDOG_PRE1 &&
    last_r != MIE_OP_WDOG_PRE2 || instr_op_in == MIE_OP_WDOG_PRE2 &&
    last_r != MIE_OP_WDOG_PRE1) |=> $stable(watchdog_timeout_flag_out) &&
    $stable(power_down_flag_out)) else $error("Lone pre-clear acted.");
endmodule
bind mie_core mie_core_monitor #(.PC_W(PC_W)) u_mon (.*);
`default_nettype wire

// File: tb/mie_core_tb_top.sv
// Self-checking bench of the execute unit.
`timescale 1ns/1ps
`default_nettype none
module mie_core_tb_top;
  import mie_pkg::*;
  localparam int PW = MIE_PC_W_DEF;
  logic ref_clk_in, reset_n_in, instr_valid_in, wdog_timeout_in, wake_in;
  mie_op_t instr_op_in;
  logic [7:0] instr_mem_addr_in, instr_imm_in, mem_operand_in, t, w;
  logic [7:0] table_pointer_in, mem_waddr_out, mem_wdata_out;
  logic [7:0] working_register_out, table_high_byte_reg_out;
  logic [2:0] instr_bit_in;
  logic [15:0] rom_rdata_in;
  logic [PW-1:0] instr_target_in, pc_out, rom_addr_out, pc;
  logic instr_ready_out, mem_we_out, rom_re_out, carry_flag_out;
  logic auxiliary_carry_flag_out, zero_flag_out, signed_overflow_flag_out;
  logic watchdog_timeout_flag_out, power_down_flag_out, halted_out;
  logic master_interrupt_enable_out, watchdog_clear_out;
  logic c, ac, z, ov, to, pd, ie;
  logic [6:0] flg;
  logic [7:0] mem [256];
  logic [PW-1:0] stk [$];
  int err_count, n_compared, pre, n;
  mie_core DUT (.*);
  // Combinational memory; flags gathered for one compare.
  assign mem_operand_in = mem[instr_mem_addr_in];
  assign flg = {carry_flag_out, auxiliary_carry_flag_out, zero_flag_out,
    signed_overflow_flag_out, watchdog_timeout_flag_out,
    power_down_flag_out, master_interrupt_enable_out};
  // Memory takes the registered write.
  always @(posedge ref_clk_in)
    if (mem_we_out === 1'b1) mem[mem_waddr_out] <= mem_wdata_out;
  // Free-running core clock.
  initial begin
    ref_clk_in = 0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One-cycle timeout pulse.
  task automatic tmo();
    @(posedge ref_clk_in);
    wdog_timeout_in <= 1'b1;
    @(posedge ref_clk_in);
    wdog_timeout_in <= 1'b0;
    to = 1;
  endtask
  // Issue one instruction, step the model, compare results.
  task automatic run(mie_op_t o, logic [7:0] a = 8'h00,
    logic [7:0] x = 8'h00);
    logic [8:0] s;
    logic [7:0] m, y, r;
    logic we, dw, two, tb, wc;
    int p;
    @(posedge ref_clk_in);
    instr_op_in <= o;
    instr_mem_addr_in <= a;
    instr_imm_in <= x;
    instr_bit_in <= x[2:0];
    instr_target_in <= {a[5:0], x};
    instr_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    instr_valid_in <= 1'b0;
    @(negedge ref_clk_in);
    m = mem[a];
    y = (o == MIE_OP_ADD_W_IMM || o == MIE_OP_AND_W_IMM) ? x : m;
    s = w + y + (c & (o == MIE_OP_ADC_W || o == MIE_OP_ADC_M));
    r = m;
    {we, dw, two, tb, wc} = '0;
    p = pre;
    pre = 0;
    pc = pc + 1;
    case (o)
      MIE_OP_ADC_W, MIE_OP_ADC_M, MIE_OP_ADD_W_MEM, MIE_OP_ADD_W_IMM,
      MIE_OP_ADD_M: begin
        r = s[7:0];
        {c, ac, z} = {s[8], w[4] ^ y[4] ^ s[4], r == 0};
        ov = (w[7] == y[7]) && (s[7] != w[7]);
        we = (o == MIE_OP_ADC_M || o == MIE_OP_ADD_M);
        dw = !we;
      end
      MIE_OP_AND_W_MEM, MIE_OP_AND_W_IMM, MIE_OP_AND_M: begin
        r = w & y;
        z = (r == 0);
        we = (o == MIE_OP_AND_M);
        dw = !we;
      end
      MIE_OP_SKZ, MIE_OP_SKZ_W: begin
        two = (m == 0);
        dw = (o == MIE_OP_SKZ_W);
      end
      MIE_OP_SKZ_BIT: two = !m[x[2:0]];
      MIE_OP_SKNZ_BIT: two = m[x[2:0]];
      MIE_OP_SKINC, MIE_OP_SKINC_W, MIE_OP_SKDEC, MIE_OP_SKDEC_W: begin
        r = (o == MIE_OP_SKINC || o == MIE_OP_SKINC_W) ? m + 1 : m - 1;
        two = (r == 0);
        we = (o == MIE_OP_SKINC || o == MIE_OP_SKDEC);
        dw = !we;
      end
      MIE_OP_JUMP: {pc, two} = {instr_target_in, 1'b1};
      MIE_OP_CALL: begin
        stk.push_back(pc);
        {pc, two} = {instr_target_in, 1'b1};
      end
      MIE_OP_RETURN, MIE_OP_RETURN_IMM, MIE_OP_RETURN_INT: begin
        pc = stk.pop_back();
        two = 1;
        if (o == MIE_OP_RETURN_IMM) w = x;
        if (o == MIE_OP_RETURN_INT) ie = 1;
      end
      MIE_OP_TBL_CUR, MIE_OP_TBL_LAST: {two, tb} = 2'b11;
      MIE_OP_CLR_M: {we, r} = {1'b1, 8'h00};
      MIE_OP_SET_M: {we, r} = {1'b1, 8'hff};
      MIE_OP_CLR_BIT: {we, r} = {1'b1, m & ~(8'h01 << x[2:0])};
      MIE_OP_SWAP_M, MIE_OP_SWAP_W: begin
        r = {m[3:0], m[7:4]};
        we = (o == MIE_OP_SWAP_M);
        dw = !we;
      end
      MIE_OP_WDOG_CLR: {to, pd, wc} = 3'b001;
      MIE_OP_WDOG_PRE1, MIE_OP_WDOG_PRE2: begin
        if (p != 0 && p != o) {to, pd} = 2'b00;
        else pre = o;
      end
      MIE_OP_HALT: {to, pd, wc} = 3'b011;
      default: ;
    endcase
    if (o >= MIE_OP_SKZ && o <= MIE_OP_SKDEC_W) pc = pc + two;
    if (dw) w = r;
    if (we && a == MIE_PCL_ADDR_DEF) {pc[7:0], two} = {r, 1'b1};
    chk("ready", instr_ready_out, !two && o != MIE_OP_HALT);
    chk("pc", pc_out, pc);
    chk("wreg", working_register_out, w);
    chk("flags", flg, {c, ac, z, ov, to, pd, ie});
    chk("we", mem_we_out, we);
    if (we) chk("wr", {mem_waddr_out, mem_wdata_out}, {a, r});
    chk("rom_re", rom_re_out, tb);
    if (wc) chk("wdclr", watchdog_clear_out, 1'b1);
    if (tb) begin
      chk("rom_a", rom_addr_out, {o == MIE_OP_TBL_LAST ? {PW-8{1'b1}} :
        pc[PW-1:8], table_pointer_in});
      @(negedge ref_clk_in);
      {t, r} = rom_rdata_in;
      chk("tbl", {table_high_byte_reg_out, mem_wdata_out}, {t, r});
      chk("tbl_we", {mem_we_out, mem_waddr_out}, {1'b1, a});
    end else if (two) @(negedge ref_clk_in);
    if (two) chk("ready2", instr_ready_out, 1'b1);
    if (o == MIE_OP_HALT) begin
      chk("halted", halted_out, 1'b1);
      @(posedge ref_clk_in);
      wake_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      wake_in <= 1'b0;
      for (int i = 0; i < 8 && instr_ready_out !== 1'b1; i++)
        @(negedge ref_clk_in);
      chk("woke", {instr_ready_out, halted_out}, 2'b10);
    end
  endtask
  // Watchdog: about a hundred and twenty times the expected run.
  initial begin
    #5_000_000;
    err_count++;
    end_sim();
  end
  // Random mix, then directed corners.
  initial begin
    void'($urandom(32'h34cc_f644));
    {reset_n_in, instr_valid_in, wdog_timeout_in, wake_in} = '0;
    {instr_mem_addr_in, instr_imm_in, instr_bit_in, instr_target_in} = '0;
    {table_pointer_in, rom_rdata_in, instr_op_in} = '0;
    {w, t, c, ac, z, ov, to, pd, ie, pc, pre} = '0;
    foreach (mem[i]) mem[i] = (i % 3 == 0) ? 8'h00 : 8'($urandom);
    repeat (10) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    for (int k = 0; k < 150; k++) begin
      n = $urandom_range(0, 26);
      run(mie_op_t'(n < 18 ? n : n + 6), {4'h1, 4'($urandom)}, 8'($urandom));
    end
    run(MIE_OP_ADD_M, MIE_PCL_ADDR_DEF);
    run(MIE_OP_CLR_M, MIE_PCL_ADDR_DEF);
    for (int k = 0; k < 3; k++) run(MIE_OP_CALL, 8'h05, 8'($urandom));
    for (int k = 0; k < 3; k++) run(mie_op_t'(MIE_OP_RETURN + k), 8'h00, 8'h5a);
    for (int k = 0; k < 2; k++) begin
      run(MIE_OP_JUMP, 8'h05, 8'h20);
      @(posedge ref_clk_in);
      {table_pointer_in, rom_rdata_in} <= 24'($urandom);
      run(k ? MIE_OP_TBL_LAST : MIE_OP_TBL_CUR, 8'h20);
    end
    run(MIE_OP_HALT);
    tmo();
    run(MIE_OP_WDOG_PRE1);
    run(MIE_OP_WDOG_PRE1);
    run(MIE_OP_NOP);
    run(MIE_OP_WDOG_PRE2);
    run(MIE_OP_WDOG_PRE1);
    tmo();
    run(MIE_OP_WDOG_CLR);
    end_sim();
  end
endmodule
`default_nettype wire
